// ### verilog/sptm_pkg.sv
/*
  Constants for the serial port and baud timer block: register byte
  addresses, bit-address bases, field positions, reset values, timer
  modes, serial state codes and timing figures.
  Assumes a 100 MHz system clock and an 8-bit special-function bus.
*/
package sptm_pkg;
  // ----------------------------------------------------------------
  // Byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_TIMER_CTRL = 8'h88;
  localparam logic [7:0] ADR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADR_T0_LOW     = 8'h8a;
  localparam logic [7:0] ADR_T1_LOW     = 8'h8b;
  localparam logic [7:0] ADR_T0_HIGH    = 8'h8c;
  localparam logic [7:0] ADR_T1_HIGH    = 8'h8d;
  localparam logic [7:0] ADR_MAIN_CTRL  = 8'h98;
  localparam logic [7:0] ADR_MAIN_DATA  = 8'h99;
  localparam logic [7:0] ADR_AUX_CTRL   = 8'h9a;
  localparam logic [7:0] ADR_AUX_DATA   = 8'h9b;
  // Bit-address bases, bit n of the register sits at base + n
  localparam logic [7:0] BIT_TIMER_BASE = 8'h88;
  localparam logic [7:0] BIT_MAIN_BASE  = 8'h98;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         SC_RX_FLAG     = 0;
  localparam int         SC_TX_FLAG     = 1;
  localparam int         SC_RX_EN       = 4;
  localparam logic [7:0] SC_RESET       = 8'h00;
  localparam int         TM_STRIDE      = 4;
  localparam int         TM_CT_BIT      = 2;
  localparam int         TM_GATE_BIT    = 3;
  localparam logic [7:0] TM_RESET       = 8'h00;
  localparam int         TC_T0_RUN      = 4;
  localparam int         TC_T0_OVF      = 5;
  localparam int         TC_STRIDE      = 2;
  localparam logic [7:0] TC_WR_MASK     = 8'hf0;
  localparam logic [7:0] TC_RESET       = 8'h00;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_16BIT     = 2'b01;
  localparam logic [1:0] MODE_8BIT      = 2'b10;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } sptm_rx_state_type;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_HZ         = 100_000_000;
  localparam int         MAX_BAUD_BPS   = 921600;
  localparam int         MIN_BIT_CYC    = CLK_HZ / MAX_BAUD_BPS;
  localparam logic [3:0] TX_FRAME_BITS  = 4'ha;
  localparam logic [2:0] RX_LAST_BIT    = 3'h7;
endpackage

// ### verilog/sptm_timer.sv
/*
  One baud timer: 16-bit up counter with reload, or 8-bit auto-reload.
  Assumes run, count source and event pulse already synchronised.
*/
`timescale 1ns/10ps
module sptm_timer
  import sptm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Configuration
  input  wire logic [1:0]  mode_i,
  input  wire logic        count_src_i,
  input  wire logic        run_i,
  input  wire logic        event_i,
  // Byte writes
  input  wire logic        wr_low_i,
  input  wire logic        wr_high_i,
  input  wire logic [7:0]  wdata_i,
  // Status
  output logic      [15:0] count_o,
  output logic             ovf_o
);
  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic        ovf_reg;
  logic        tick;

  // Clock count, or event pulses when the source bit is set
  assign tick    = run_i && (count_src_i ? event_i : 1'b1);
  assign count_o = count_reg;
  assign ovf_o   = ovf_reg;

  // Reload value follows software writes
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      reload_reg <= 16'h0000;
    else if (wr_low_i)
      reload_reg[7:0] <= wdata_i;
    else if (wr_high_i)
      reload_reg[15:8] <= wdata_i;
  end

  // Counting, overflow and reload
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_reg <= 16'h0000;
      ovf_reg   <= 1'b0;
    end
    else
    begin
      ovf_reg <= 1'b0;
      if (wr_low_i)
        count_reg[7:0] <= wdata_i;
      else if (wr_high_i)
        count_reg[15:8] <= wdata_i;
      else if (tick && mode_i == MODE_16BIT)
      begin
        if (count_reg == 16'hffff)
        begin
          count_reg <= reload_reg;
          ovf_reg   <= 1'b1;
        end
        else
          count_reg <= count_reg + 16'h0001;
      end
      else if (tick && mode_i == MODE_8BIT)
      begin
        if (count_reg[7:0] == 8'hff)
        begin
          count_reg[7:0] <= count_reg[15:8];
          ovf_reg        <= 1'b1;
        end
        else
          count_reg[7:0] <= count_reg[7:0] + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wrap_reload;
    @(posedge mclk_i) disable iff (reset_i)
    (tick && mode_i == MODE_16BIT && count_reg == 16'hffff && !wr_low_i && !wr_high_i)
      |=> (ovf_reg && count_reg == $past(reload_reg));
  endproperty
  a_wrap_reload: assert property (p_wrap_reload)
    else $error("16-bit wrap did not reload and pulse");

  property p_stopped_holds;
    @(posedge mclk_i) disable iff (reset_i)
    (!run_i && !wr_low_i && !wr_high_i) |=> ($stable(count_reg) && !ovf_reg);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("Timer moved while stopped");
endmodule

// ### verilog/sptm_serial_top.sv
/*
  Two serial ports with their two baud timers behind a byte-wide and a
  bit-wide special-function register port.
  Assumes a processor that issues one-cycle read and write strobes; the
  serial and gate pins are asynchronous and are synchronised here.
*/
`timescale 1ns/10ps
module sptm_serial_top
  import sptm_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  // Byte register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // Bit register port
  input  wire logic [7:0] bit_addr_i,
  input  wire logic       bit_wr_i,
  input  wire logic       bit_rd_i,
  input  wire logic       bit_wdata_i,
  output logic            bit_rdata_o,
  // Serial pins
  input  wire logic       rxd_main_i,
  output logic            txd_main_o,
  input  wire logic       rxd_aux_i,
  output logic            txd_aux_o,
  // Timer gate and event pins
  input  wire logic       ext_gate_input0_i,
  input  wire logic       ext_gate_input1_i,
  input  wire logic       ext_event0_i,
  input  wire logic       ext_event1_i
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  tctl_reg;
  logic [7:0]  tmode_reg;
  logic [7:0]  rdata_reg;
  logic        bit_rdata_reg;
  logic [7:0]  rd_val;
  logic        bit_val;
  logic [5:0]  pin_s1_reg;
  logic [5:0]  pin_s2_reg;
  logic [1:0]  ev_prev_reg;
  logic [1:0]  ev_pulse;
  logic [1:0]  gate_in;
  logic [1:0]  rxd_in;
  logic [15:0] t_count [2];
  logic [1:0]  t_ovf;
  logic [1:0]  t_run;
  logic [7:0]  main_serial_control_reg [2];
  logic [7:0]  rx_data_reg [2];
  logic [1:0]  tx_busy_reg;
  logic [1:0]  tx_done_reg;
  logic [1:0]  rx_done_reg;
  logic [1:0]  txd_reg;

  // True when a bit address falls in the eight bits of a register
  function automatic logic bit_hit(input logic [7:0] a, input logic [7:0] base);
    return a[7:3] == base[7:3];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages for every asynchronous pin
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_s1_reg  <= 6'h03;
      pin_s2_reg  <= 6'h03;
      ev_prev_reg <= 2'h0;
    end
    else
    begin
      pin_s1_reg  <= {ext_event1_i, ext_event0_i, ext_gate_input1_i,
                      ext_gate_input0_i, rxd_aux_i, rxd_main_i};
      pin_s2_reg  <= pin_s1_reg;
      ev_prev_reg <= pin_s2_reg[5:4];
    end
  end

  // Rising edges of the event pins, levels of the rest
  assign ev_pulse = pin_s2_reg[5:4] & ~ev_prev_reg;
  assign gate_in  = pin_s2_reg[3:2];
  assign rxd_in   = pin_s2_reg[1:0];

  // ----------------------------------------------------------------
  // Timer registers
  // ----------------------------------------------------------------
  // Mode register, plain read/write
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      tmode_reg <= TM_RESET;
    else if (sfr_wr_i && sfr_addr_i == ADR_TIMER_MODE)
      tmode_reg <= sfr_wdata_i;
  end

  // Control register: byte and bit writes, overflow set wins
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      tctl_reg <= TC_RESET;
    else
    begin
      if (sfr_wr_i && sfr_addr_i == ADR_TIMER_CTRL)
        tctl_reg <= sfr_wdata_i & TC_WR_MASK;
      else if (bit_wr_i && bit_hit(bit_addr_i, BIT_TIMER_BASE) && bit_addr_i[2])
        tctl_reg[bit_addr_i[2:0]] <= bit_wdata_i;
      if (t_ovf[0])
        tctl_reg[TC_T0_OVF] <= 1'b1;
      if (t_ovf[1])
        tctl_reg[TC_T0_OVF + TC_STRIDE] <= 1'b1;
    end
  end

  // Two timers, each gated by its run bit and optional gate pin
  for (genvar t = 0; t < 2; t++)
  begin : g_timer
    localparam int MSH = TM_STRIDE * t;
    assign t_run[t] = tctl_reg[TC_T0_RUN + TC_STRIDE * t] &&
                      (!tmode_reg[MSH + TM_GATE_BIT] || gate_in[t]);
    sptm_timer u_timer (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .mode_i      (tmode_reg[MSH +: 2]),
      .count_src_i (tmode_reg[MSH + TM_CT_BIT]),
      .run_i       (t_run[t]),
      .event_i     (ev_pulse[t]),
      .wr_low_i    (sfr_wr_i && sfr_addr_i == ADR_T0_LOW + 8'(t)),
      .wr_high_i   (sfr_wr_i && sfr_addr_i == ADR_T0_HIGH + 8'(t)),
      .wdata_i     (sfr_wdata_i),
      .count_o     (t_count[t]),
      .ovf_o       (t_ovf[t])
    );
  end

  // ----------------------------------------------------------------
  // Serial ports, 0 is main, 1 is auxiliary
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    localparam logic [7:0] CA = (p == 0) ? ADR_MAIN_CTRL : ADR_AUX_CTRL;
    localparam logic [7:0] DA = (p == 0) ? ADR_MAIN_DATA : ADR_AUX_DATA;
    localparam bit         BA = (p == 0);
    sptm_rx_state_type rx_state_reg;
    logic        baud;
    logic        wr_data;
    logic [15:0] per_cnt_reg;
    logic [15:0] per_reg;
    logic [15:0] wait_reg;
    logic [9:0]  frame_reg;
    logic [3:0]  tx_cnt_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  nbit_reg;

    assign baud    = t_ovf[1 - p];
    assign wr_data = sfr_wr_i && sfr_addr_i == DA;

    // Control register; flags clear on a written 0, hardware set wins
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
      if (reset_i)
        main_serial_control_reg[p] <= SC_RESET;
      else
      begin
        if (sfr_wr_i && sfr_addr_i == CA)
          main_serial_control_reg[p] <= {sfr_wdata_i[7:4], 2'b00,
                          main_serial_control_reg[p][1:0] & sfr_wdata_i[1:0]};
        else if (BA && bit_wr_i && bit_hit(bit_addr_i, BIT_MAIN_BASE))
        begin
          if (bit_addr_i[2:0] <= 3'(SC_TX_FLAG))
            main_serial_control_reg[p][bit_addr_i[2:0]] <= main_serial_control_reg[p][bit_addr_i[2:0]] && bit_wdata_i;
          else if (bit_addr_i[2:0] >= 3'(SC_RX_EN))
            main_serial_control_reg[p][bit_addr_i[2:0]] <= bit_wdata_i;
        end
        if (rx_done_reg[p])
          main_serial_control_reg[p][SC_RX_FLAG] <= 1'b1;
        if (tx_done_reg[p])
          main_serial_control_reg[p][SC_TX_FLAG] <= 1'b1;
      end
    end

    // Transmitter: ten-bit frame shifted out one bit per baud pulse
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        frame_reg      <= 10'h3ff;
        tx_cnt_reg     <= 4'h0;
        tx_busy_reg[p] <= 1'b0;
        tx_done_reg[p] <= 1'b0;
        txd_reg[p]     <= 1'b1;
      end
      else
      begin
        tx_done_reg[p] <= 1'b0;
        if (!tx_busy_reg[p] && wr_data)
        begin
          frame_reg      <= {1'b1, sfr_wdata_i, 1'b0};
          tx_cnt_reg     <= TX_FRAME_BITS;
          tx_busy_reg[p] <= 1'b1;
        end
        else if (tx_busy_reg[p] && baud)
        begin
          if (tx_cnt_reg == 4'h0)
          begin
            tx_busy_reg[p] <= 1'b0;
            tx_done_reg[p] <= 1'b1;
          end
          else
          begin
            txd_reg[p] <= frame_reg[0];
            frame_reg  <= {1'b1, frame_reg[9:1]};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
          end
        end
      end
    end

    // Measure the baud period in clocks for mid-bit sampling
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        per_cnt_reg <= 16'h0000;
        per_reg     <= 16'h0000;
      end
      else if (baud)
      begin
        per_cnt_reg <= 16'h0000;
        per_reg     <= per_cnt_reg + 16'h0001;
      end
      else if (per_cnt_reg != 16'hffff)
        per_cnt_reg <= per_cnt_reg + 16'h0001;
    end

    // Receiver: start check at half a bit, then one sample per bit
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        rx_state_reg   <= RX_IDLE;
        wait_reg       <= 16'h0000;
        shift_reg      <= 8'h00;
        nbit_reg       <= 3'h0;
        rx_done_reg[p] <= 1'b0;
        rx_data_reg[p] <= BYTE_RESET;
      end
      else
      begin
        rx_done_reg[p] <= 1'b0;
        if (rx_state_reg != RX_IDLE && wait_reg != 16'h0000)
          wait_reg <= wait_reg - 16'h0001;
        else
          case (rx_state_reg)
            RX_IDLE:
              if (main_serial_control_reg[p][SC_RX_EN] && !rxd_in[p])
              begin
                rx_state_reg <= RX_START;
                wait_reg     <= {1'b0, per_reg[15:1]};
              end
            RX_START:
            begin
              rx_state_reg <= rxd_in[p] ? RX_IDLE : RX_DATA;
              wait_reg     <= per_reg - 16'h0001;
              nbit_reg     <= 3'h0;
            end
            RX_DATA:
            begin
              shift_reg <= {rxd_in[p], shift_reg[7:1]};
              nbit_reg  <= nbit_reg + 3'h1;
              wait_reg  <= per_reg - 16'h0001;
              if (nbit_reg == RX_LAST_BIT)
                rx_state_reg <= RX_STOP;
            end
            RX_STOP:
            begin
              rx_state_reg <= RX_IDLE;
              if (rxd_in[p])
              begin
                rx_data_reg[p] <= shift_reg;
                rx_done_reg[p] <= 1'b1;
              end
            end
            default: rx_state_reg <= RX_IDLE;
          endcase
      end
    end
  end

  assign txd_main_o = txd_reg[0];
  assign txd_aux_o  = txd_reg[1];

  // ----------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------
  // Byte read decode
  always_comb
  begin
    case (sfr_addr_i)
      ADR_TIMER_CTRL: rd_val = tctl_reg;
      ADR_TIMER_MODE: rd_val = tmode_reg;
      ADR_T0_LOW:     rd_val = t_count[0][7:0];
      ADR_T1_LOW:     rd_val = t_count[1][7:0];
      ADR_T0_HIGH:    rd_val = t_count[0][15:8];
      ADR_T1_HIGH:    rd_val = t_count[1][15:8];
      ADR_MAIN_CTRL:  rd_val = main_serial_control_reg[0];
      ADR_MAIN_DATA:  rd_val = rx_data_reg[0];
      ADR_AUX_CTRL:   rd_val = main_serial_control_reg[1];
      ADR_AUX_DATA:   rd_val = rx_data_reg[1];
      default:        rd_val = 8'h00;
    endcase
  end

  // Bit read decode
  always_comb
  begin
    if (bit_hit(bit_addr_i, BIT_TIMER_BASE))
      bit_val = tctl_reg[bit_addr_i[2:0]];
    else if (bit_hit(bit_addr_i, BIT_MAIN_BASE))
      bit_val = main_serial_control_reg[0][bit_addr_i[2:0]];
    else
      bit_val = 1'b0;
  end

  // Registered read data, held between reads
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rdata_reg     <= BYTE_RESET;
      bit_rdata_reg <= 1'b0;
    end
    else
    begin
      if (sfr_rd_i)
        rdata_reg <= rd_val;
      if (bit_rd_i)
        bit_rdata_reg <= bit_val;
    end
  end

  assign sfr_rdata_o = rdata_reg;
  assign bit_rdata_o = bit_rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_tx_go;
    sfr_wr_i && sfr_addr_i == ADR_MAIN_DATA && !tx_busy_reg[0];
  endsequence
  sequence s_first_baud;
    tx_busy_reg[0] && t_ovf[1] && g_port[0].tx_cnt_reg == TX_FRAME_BITS;
  endsequence

  property p_tx_start;
    s_tx_go |=> tx_busy_reg[0] && g_port[0].tx_cnt_reg == TX_FRAME_BITS;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("Data write did not start a frame");

  property p_start_bit;
    s_first_baud |=> !txd_main_o;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("Frame did not open with a low start bit");

  property p_tx_flag;
    tx_done_reg[0] |=> main_serial_control_reg[0][SC_TX_FLAG] && !tx_busy_reg[0] && txd_main_o;
  endproperty
  a_tx_flag: assert property (p_tx_flag)
    else $error("Transmit flag not set after stop bit");

  property p_rd_data;
    sfr_rd_i && sfr_addr_i == ADR_MAIN_DATA |=> sfr_rdata_o == $past(rx_data_reg[0]);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("Data read did not return received byte");

  property p_ovf_flag;
    t_ovf[1] |=> tctl_reg[TC_T0_OVF + TC_STRIDE];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("Timer 1 overflow flag not set");

  property p_gate_stop;
    tmode_reg[TM_GATE_BIT] && !gate_in[0] |-> !t_run[0];
  endproperty
  a_gate_stop: assert property (p_gate_stop)
    else $error("Gated timer 0 ran with gate low");
endmodule

// ### bench/sptm_uart_peer.sv
/*
  Far-side serial peer: captures frames from a transmit line and sends
  frames on a receive line. Assumes a bit time of whole clock cycles.
*/
`timescale 1ns/10ps
module sptm_uart_peer
#(
  parameter int BIT_CYC = 32
)
(
  // Clock and lines
  input  wire logic       mclk_i,
  input  wire logic       txd_i,
  output logic            rxd_o,
  // Capture
  output logic      [7:0] got_o,
  output int              bad_stop_o
);
  // ------------------------------------------
  // Receiver: sample each bit mid-period
  // ------------------------------------------
  initial
  begin
    rxd_o = 1'b1;
    got_o = 8'h00;
    bad_stop_o = 0;
    forever
    begin
      @(posedge mclk_i iff txd_i === 1'b0);
      repeat (BIT_CYC / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge mclk_i);
        got_o[i] = txd_i;
      end
      repeat (BIT_CYC) @(posedge mclk_i);
      if (txd_i !== 1'b1)
        bad_stop_o++;
    end
  end

  // ------------------------------------------
  // Sender: start, eight bits LSB first, stop
  // ------------------------------------------
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge mclk_i);
    end
  endtask
endmodule

// ### bench/serial_port_with_baud_timer_tb.sv
/*
  Self-checking bench for the serial port and baud timer block.
  Assumes two peer models on the lines; 100 MHz clock.
*/
`timescale 1ns/10ps
module serial_port_with_baud_timer_tb;
  logic       clk, rst, wr_s, rd_s, bwr_s, brd_s, bwd, brdata;
  logic       rxm, txm, rxa, txa, g0, ev0, g1, ev1;
  logic [7:0] adr, wd, rdata, badr, gm, ga, v1, v2, ca;
  int         errors, checks_done, bm, ba;

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  sptm_serial_top dut (.mclk_i(clk), .reset_i(rst), .sfr_addr_i(adr), .sfr_wr_i(wr_s),
    .sfr_rd_i(rd_s), .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .bit_addr_i(badr),
    .bit_wr_i(bwr_s), .bit_rd_i(brd_s), .bit_wdata_i(bwd), .bit_rdata_o(brdata),
    .rxd_main_i(rxm), .txd_main_o(txm), .rxd_aux_i(rxa), .txd_aux_o(txa),
    .ext_gate_input0_i(g0), .ext_gate_input1_i(g1), .ext_event0_i(ev0),
    .ext_event1_i(ev1));
  sptm_uart_peer #(.BIT_CYC(32)) peer_main (.mclk_i(clk), .txd_i(txm), .rxd_o(rxm),
    .got_o(gm), .bad_stop_o(bm));
  sptm_uart_peer #(.BIT_CYC(64)) peer_aux (.mclk_i(clk), .txd_i(txa), .rxd_o(rxa),
    .got_o(ga), .bad_stop_o(ba));

  // ------------------------------------------
  // Access and compare tasks
  // ------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    cyc(1);
    adr = a;
    wd = d;
    wr_s = 1'b1;
    cyc(1);
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    cyc(1);
    adr = a;
    rd_s = 1'b1;
    cyc(1);
    rd_s = 1'b0;
    v = rdata;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, exp);
    logic [7:0] v;
    rd(a, v);
    chk(nm, v, exp);
  endtask
  task automatic bwr(input logic [7:0] a, input logic d);
    cyc(1);
    badr = a;
    bwd = d;
    bwr_s = 1'b1;
    cyc(1);
    bwr_s = 1'b0;
  endtask
  task automatic brd(input logic [7:0] a, output logic [7:0] v);
    cyc(1);
    badr = a;
    brd_s = 1'b1;
    cyc(1);
    brd_s = 1'b0;
    v = {7'h00, brdata};
  endtask
  task automatic poll(input string nm, input logic [7:0] a, input int b);
    logic [7:0] v;
    v = 8'h00;
    for (int n = 0; n < 3000 && v[b] !== 1'b1; n++)
      rd(a, v);
    chk(nm, {7'h00, v[b]}, 8'h01);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    tally_and_finish;
  end

  // ------------------------------------------
  // Test sequence
  // ------------------------------------------
  initial
  begin
    {rst, wr_s, rd_s, bwr_s, brd_s, bwd, g0, ev0, g1, ev1} = 10'h200;
    {adr, wd, badr} = 24'h000000;
    errors = 0;
    checks_done = 0;
    cyc(2);
    rst = 1'b0;
    rdchk("timer_control_flags_rst", 8'h88, 8'h00);
    rdchk("timer_mode_config_rst", 8'h89, 8'h00);
    rdchk("main_serial_control_rst", 8'h98, 8'h00);
    wr(8'h88, 8'h0c);
    rdchk("timer_control_flags_rsvd", 8'h88, 8'h00);
    rdchk("unmapped", 8'h90, 8'h00);
    wr(8'h8a, 8'hc0);
    wr(8'h8b, 8'he0);
    wr(8'h8c, 8'hff);
    wr(8'h8d, 8'hff);
    rdchk("t1_high", 8'h8d, 8'hff);
    rdchk("t0_low", 8'h8a, 8'hc0);
    wr(8'h89, 8'h11);
    rdchk("timer_mode_config", 8'h89, 8'h11);
    bwr(8'h8c, 1'b1);
    bwr(8'h8e, 1'b1);
    cyc(70);
    rdchk("timer_control_flags_ovf", 8'h88, 8'hf0);
    brd(8'h8f, v1);
    chk("bit_tf1", v1, 8'h01);
    bwr(8'h9c, 1'b1);
    rdchk("bit_ren", 8'h98, 8'h10);
    bwr(8'h9d, 1'b1);
    rdchk("bit_mode", 8'h98, 8'h30);
    bwr(8'h9d, 1'b0);
    wr(8'h9a, 8'h10);
    for (int p = 0; p < 2; p++)
    begin
      ca = p ? 8'h9a : 8'h98;
      wr(ca + 8'h01, p ? 8'h3c : 8'ha5);
      poll("tx_flag", ca, 1);
      chk("tx_byte", p ? ga : gm, p ? 8'h3c : 8'ha5);
      wr(ca, 8'h10);
      rdchk("tx_clear", ca, 8'h10);
      wr(ca + 8'h01, 8'h96);
      wr(ca + 8'h01, 8'h00);
      poll("tx_flag2", ca, 1);
      chk("busy_drop", p ? ga : gm, 8'h96);
      wr(ca, 8'h10);
      if (p)
        peer_aux.send(8'hc3);
      else
        peer_main.send(8'h5a);
      poll("rx_flag", ca, 0);
      rdchk("rx_byte", ca + 8'h01, p ? 8'hc3 : 8'h5a);
    end
    chk("stop_bits", 8'(bm + ba), 8'h00);
    // Event counting in 8-bit mode, timer 0 then timer 1
    for (int t = 0; t < 2; t++)
    begin
      wr(8'h89, t ? 8'h62 : 8'h16);
      wr(8'h8a + 8'(t), 8'h10);
      repeat (3)
      begin
        {ev1, ev0} = t ? 2'b10 : 2'b01;
        cyc(3);
        {ev1, ev0} = 2'b00;
        cyc(3);
      end
      cyc(4);
      rdchk("events", 8'h8a + 8'(t), 8'h13);
    end
    // Both timers gated, 16-bit mode, count source clear
    wr(8'h89, 8'h99);
    wr(8'h8a, 8'h20);
    wr(8'h8b, 8'h20);
    cyc(5);
    rdchk("gate_low", 8'h8a, 8'h20);
    g0 = 1'b1;
    cyc(4);
    rd(8'h8a, v1);
    cyc(3);
    rd(8'h8a, v2);
    chk("count_rate", v2 - v1, 8'h05);
    rdchk("gate1_low", 8'h8b, 8'h20);
    g1 = 1'b1;
    cyc(4);
    rd(8'h8b, v1);
    chk("gate1_run", {7'h00, v1 != 8'h20}, 8'h01);
    bwr(8'h8c, 1'b0);
    cyc(3);
    rd(8'h8a, v1);
    cyc(3);
    rd(8'h8a, v2);
    chk("run_off", v2 - v1, 8'h00);
    wr(8'h89, 8'h12);
    wr(8'h8c, 8'hf0);
    wr(8'h8a, 8'hf0);
    bwr(8'h8c, 1'b1);
    cyc(40);
    rd(8'h8a, v1);
    chk("mode8", {7'h00, v1 >= 8'hf0}, 8'h01);
    tally_and_finish;
  end
endmodule
